// >>> core/tvu_pkg.sv
package tvu_pkg;
  // ***********************************************
  // widths and trap numbers
  // ***********************************************
  localparam int unsigned VEC_W = 24;
  localparam int unsigned TRAP_W = 7;
  localparam int unsigned VEC_SHIFT = 2;
  localparam logic [TRAP_W-1:0] TRAP_RESET = 7'h00;
  localparam logic [TRAP_W-1:0] TRAP_UNMASK = 7'h02;
  localparam logic [TRAP_W-1:0] TRAP_STK_OVER = 7'h04;
  localparam logic [TRAP_W-1:0] TRAP_STK_UNDER = 7'h06;
  localparam logic [TRAP_W-1:0] TRAP_FAULT = 7'h0a;
  localparam logic [TRAP_W-1:0] TRAP_TIMER0 = 7'h20;
  localparam logic [TRAP_W-1:0] TRAP_TX_DONE = 7'h2a;
  localparam logic [TRAP_W-1:0] TRAP_TX_BUF = 7'h47;
  localparam logic [VEC_W-1:0] VEC_TX_BUF = 24'h00011c;
  localparam logic [VEC_W-1:0] VEC_FAULT = 24'h000028;
  localparam logic [VEC_W-1:0] VEC_ZERO = 24'h000000;
  // default node table: timer 0, transmit done, transmit buffer empty
  localparam int unsigned NODE_NUM = 3;
  localparam logic [NODE_NUM-1:0][TRAP_W-1:0] NODE_TRAPS =
    {TRAP_TX_BUF, TRAP_TX_DONE, TRAP_TIMER0};

  // ***********************************************
  // trap_cause_flags bit positions
  // ***********************************************
  localparam int unsigned FLG_W = 8;
  localparam int unsigned FLG_UNMASK = 0;
  localparam int unsigned FLG_STK_OVER = 1;
  localparam int unsigned FLG_STK_UNDER = 2;
  localparam int unsigned FLG_FAULT_LO = 3;
  localparam int unsigned FAULT_NUM = 5;
  localparam int unsigned CLASS_A_NUM = 3;

  // ***********************************************
  // register map (byte addresses) and reset values
  // ***********************************************
  localparam logic [7:0] REG_FLAGS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_NODE_REQ = 8'h08;
  localparam logic [7:0] REG_NODE_EN = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_RESET, SRC_A, SRC_B, SRC_SOFT, SRC_NODE
  } tvu_src_type;

  typedef struct packed {
    logic valid;
    logic is_reset;
    logic [TRAP_W-1:0] trap_num;
    logic [VEC_W-1:0] vector;
  } tvu_branch_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } tvu_wb_req_type;
endpackage

// >>> core/tvu_trap_unit.sv
// Implementation choices: the register addresses and the Wishbone register port.
module tvu_trap_unit
  import tvu_pkg::*;
#(
  parameter int unsigned NODES = NODE_NUM,
  parameter logic [NODES-1:0][TRAP_W-1:0] NODE_TRAP = NODE_TRAPS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tvu_wb_req_type wb_req_in,
  output tvu_branch_type branch_out,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic irq_out,
  output logic [1:0] service_out,
  input wire logic unmaskable_req_n_in,
  input wire logic stack_overrun_in,
  input wire logic stack_underrun_in,
  input wire logic [FAULT_NUM-1:0] fault_in,
  input wire logic soft_reset_in,
  input wire logic watchdog_overflow_in,
  input wire logic soft_trap_in,
  input wire logic [TRAP_W-1:0] soft_trap_num_in,
  input wire logic [NODES-1:0] node_event_in,
  input wire logic branch_ack_in,
  input wire logic service_done_in
);

  // ***********************************************
  // state
  // ***********************************************
  logic [FLG_W-1:0] trap_cause_flags_reg;
  logic [FLG_W-1:0] mask_reg;
  logic [NODES-1:0] node_req_reg;
  logic [NODES-1:0] node_en_reg;
  logic ien_reg;
  logic [CLASS_A_NUM-1:0] pend_a_reg;
  logic pend_b_reg;
  logic pend_rst_reg;
  logic soft_pend_reg;
  logic [TRAP_W-1:0] soft_num_reg;
  logic svc_a_reg;
  logic svc_b_reg;
  tvu_src_type src_reg;
  logic [TRAP_W-1:0] idx_reg;
  tvu_branch_type branch_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic irq_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;

  // ***********************************************
  // unmaskable pin synchroniser, falling edge
  // ***********************************************
  // pin is asynchronous: two flops before the edge detector
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
    end else begin
      sync1_reg <= unmaskable_req_n_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  wire unmask_edge = sync3_reg & ~sync2_reg;

  // ***********************************************
  // wishbone decode
  // ***********************************************
  wire bus_req = wb_req_in.cyc & wb_req_in.stb;
  wire bus_commit = bus_req & ack_reg;
  wire wr_en = bus_commit & wb_req_in.we & wb_req_in.sel[0];
  wire hit_flags = wb_req_in.adr == REG_FLAGS;
  wire hit_mask = wb_req_in.adr == REG_MASK;
  wire hit_nreq = wb_req_in.adr == REG_NODE_REQ;
  wire hit_nen = wb_req_in.adr == REG_NODE_EN;
  wire hit_ctrl = wb_req_in.adr == REG_CTRL;
  wire hit_stat = wb_req_in.adr == REG_STAT;
  wire [FLG_W-1:0] flag_clr = (wr_en & hit_flags) ? wb_req_in.dat[FLG_W-1:0] : '0;
  wire [NODES-1:0] nreq_clr = (wr_en & hit_nreq) ? wb_req_in.dat[NODES-1:0] : '0;
  // unmapped addresses read zero and ignore writes
  wire [31:0] rd_data =
    hit_flags ? {{(32-FLG_W){1'b0}}, trap_cause_flags_reg} :
    hit_mask ? {{(32-FLG_W){1'b0}}, mask_reg} :
    hit_nreq ? {{(32-NODES){1'b0}}, node_req_reg} :
    hit_nen ? {{(32-NODES){1'b0}}, node_en_reg} :
    hit_ctrl ? {31'h0, ien_reg} :
    hit_stat ? {25'h0, pend_rst_reg, pend_b_reg, pend_a_reg, svc_b_reg, svc_a_reg} :
    RD_ZERO;

  // ***********************************************
  // trap events and flags
  // ***********************************************
  wire [CLASS_A_NUM-1:0] a_event = {stack_underrun_in, stack_overrun_in, unmask_edge};
  wire b_event = |fault_in;
  wire rst_event = soft_reset_in | watchdog_overflow_in;
  wire [FLG_W-1:0] flag_set = {fault_in, a_event};
  // set wins over a write-one clear in the same cycle
  wire [FLG_W-1:0] flags_next = (trap_cause_flags_reg & ~flag_clr) | flag_set;

  // ***********************************************
  // selection among pending work
  // ***********************************************
  wire taken = branch_reg.valid & branch_ack_in;
  wire take_a = |pend_a_reg & ~svc_a_reg;
  wire take_b = pend_b_reg & ~svc_a_reg & ~svc_b_reg;
  wire in_trap = svc_a_reg | svc_b_reg;
  // trap services shut out ordinary nodes
  wire [NODES-1:0] node_live = node_req_reg & node_en_reg & {NODES{ien_reg & ~in_trap}};
  wire [1:0] a_idx = pend_a_reg[FLG_UNMASK] ? 2'd0 : pend_a_reg[FLG_STK_OVER] ? 2'd1 : 2'd2;
  wire [TRAP_W-1:0] a_trap = (a_idx == 2'd0) ? TRAP_UNMASK :
                            (a_idx == 2'd1) ? TRAP_STK_OVER : TRAP_STK_UNDER;
  logic [TRAP_W-1:0] node_idx;
  logic [TRAP_W-1:0] node_trap;

  // lowest node index wins; level arbitration lives elsewhere
  always_comb begin
    node_idx = '0;
    node_trap = NODE_TRAP[0];
    for (int i = NODES - 1; i >= 0; i--) begin
      if (node_live[i]) begin
        node_idx = TRAP_W'(i);
        node_trap = NODE_TRAP[i];
      end
    end
  end

  // fixed order: reset, class A, class B, software trap, nodes
  wire tvu_src_type sel_src = pend_rst_reg ? SRC_RESET :
                               take_a ? SRC_A :
                               take_b ? SRC_B :
                               soft_pend_reg ? SRC_SOFT :
                               (|node_live) ? SRC_NODE : SRC_NONE;
  wire [TRAP_W-1:0] sel_trap = (sel_src == SRC_RESET) ? TRAP_RESET :
                               (sel_src == SRC_A) ? a_trap :
                               (sel_src == SRC_B) ? TRAP_FAULT :
                               (sel_src == SRC_SOFT) ? soft_num_reg : node_trap;
  wire [TRAP_W-1:0] sel_idx = (sel_src == SRC_A) ? TRAP_W'(a_idx) : node_idx;
  // vector is always four times the trap number
  wire [VEC_W-1:0] sel_vec = {{(VEC_W-TRAP_W-VEC_SHIFT){1'b0}}, sel_trap, 2'b00};

  // ***********************************************
  // offer register toward the sequencer
  // ***********************************************
  // offer is re-chosen each cycle so a later reset or class A overtakes;
  // one idle cycle after each acknowledge avoids re-offering stale work
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      branch_reg <= '0;
      src_reg <= SRC_NONE;
      idx_reg <= '0;
    end else if (taken) begin
      branch_reg.valid <= 1'b0;
      src_reg <= SRC_NONE;
    end else begin
      branch_reg.valid <= sel_src != SRC_NONE;
      branch_reg.is_reset <= sel_src == SRC_RESET;
      branch_reg.trap_num <= sel_trap;
      branch_reg.vector <= sel_vec;
      src_reg <= sel_src;
      idx_reg <= sel_idx;
    end
  end

  // ***********************************************
  // pending traps and service nesting
  // ***********************************************
  wire ack_rst = taken & (src_reg == SRC_RESET);
  wire ack_a = taken & (src_reg == SRC_A);
  wire ack_b = taken & (src_reg == SRC_B);
  wire [CLASS_A_NUM-1:0] a_clr = ack_a ? CLASS_A_NUM'(1) << idx_reg[1:0] : '0;

  // hardware reset leaves a reset branch pending
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_rst_reg <= 1'b1;
      pend_a_reg <= '0;
      pend_b_reg <= 1'b0;
    end else begin
      pend_rst_reg <= rst_event | (pend_rst_reg & ~ack_rst);
      pend_a_reg <= a_event | (pend_a_reg & ~a_clr & {CLASS_A_NUM{~ack_rst}});
      pend_b_reg <= b_event | (pend_b_reg & ~ack_b & ~ack_rst);
    end
  end

  // class A may nest over class B; done pops the innermost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      svc_a_reg <= 1'b0;
      svc_b_reg <= 1'b0;
    end else if (ack_rst) begin
      svc_a_reg <= 1'b0;
      svc_b_reg <= 1'b0;
    end else begin
      svc_a_reg <= ack_a | (svc_a_reg & ~service_done_in);
      svc_b_reg <= ack_b | (svc_b_reg & ~(service_done_in & ~svc_a_reg));
    end
  end

  // software trap runs at current priority: no class gating
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      soft_pend_reg <= 1'b0;
      soft_num_reg <= '0;
    end else begin
      soft_pend_reg <= soft_trap_in | (soft_pend_reg & ~(taken & (src_reg == SRC_SOFT)));
      if (soft_trap_in) begin
        soft_num_reg <= soft_trap_num_in;
      end
    end
  end

  // ***********************************************
  // interrupt nodes
  // ***********************************************
  wire [NODES-1:0] node_clr =
    (taken & (src_reg == SRC_NODE)) ? NODES'(1) << idx_reg : '0;

  // request flag set wins over service and write-one clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      node_req_reg <= '0;
    end else begin
      node_req_reg <= node_event_in | (node_req_reg & ~node_clr & ~nreq_clr);
    end
  end

  // ***********************************************
  // software registers and bus answer
  // ***********************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trap_cause_flags_reg <= '0;
      mask_reg <= MASK_RST;
      node_en_reg <= '0;
      ien_reg <= 1'b0;
    end else begin
      trap_cause_flags_reg <= flags_next;
      if (wr_en & hit_mask) begin
        mask_reg <= wb_req_in.dat[FLG_W-1:0];
      end
      if (wr_en & hit_nen) begin
        node_en_reg <= wb_req_in.dat[NODES-1:0];
      end
      if (wr_en & hit_ctrl) begin
        ien_reg <= wb_req_in.dat[0];
      end
    end
  end

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      dat_reg <= rd_data;
      irq_reg <= |(flags_next & mask_reg); // mask gates the pin only
    end
  end

  assign branch_out = branch_reg;
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;
  assign irq_out = irq_reg;
  assign service_out = {svc_b_reg, svc_a_reg};

  // ***********************************************
  // assertions
  // ***********************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  vec_times_four_a: assert property (
    branch_reg.valid |-> branch_reg.vector == VEC_W'({branch_reg.trap_num, 2'b00}))
    else $error("vector is not four times trap number");
  tx_buf_vec_a: assert property (
    branch_reg.valid && src_reg == SRC_NODE && branch_reg.trap_num == TRAP_TX_BUF
    |-> branch_reg.vector == VEC_TX_BUF)
    else $error("transmit buffer vector wrong");
  class_a_offer_a: assert property (
    |pend_a_reg && !svc_a_reg && !pend_rst_reg && !taken
    |=> branch_reg.valid && src_reg == SRC_A)
    else $error("class A trap not offered next cycle");
  flag_sets_a: assert property (
    stack_overrun_in ##1 !(wr_en && hit_flags) |-> trap_cause_flags_reg[FLG_STK_OVER])
    else $error("stack overrun flag not set");
  held_off_a: assert property (
    svc_a_reg && !pend_rst_reg |=> !(branch_reg.valid && src_reg == SRC_B))
    else $error("class B offered during class A service");
  no_node_trap_a: assert property (
    in_trap |=> !(branch_reg.valid && src_reg == SRC_NODE))
    else $error("node offered during trap service");
  fault_vec_a: assert property (
    branch_reg.valid && src_reg == SRC_B
    |-> branch_reg.trap_num == TRAP_FAULT && branch_reg.vector == VEC_FAULT)
    else $error("fault class vector wrong");
  reset_first_a: assert property (
    pend_rst_reg && !taken |=> branch_reg.valid && branch_reg.is_reset
    && branch_reg.vector == VEC_ZERO)
    else $error("reset not offered first");
  class_a_vec_a: assert property (
    branch_reg.valid && src_reg == SRC_A
    |-> branch_reg.vector inside {24'h000008, 24'h000010, 24'h000018})
    else $error("class A vector wrong");
  soft_trap_a: assert property (
    branch_reg.valid && src_reg == SRC_SOFT |-> branch_reg.trap_num == soft_num_reg)
    else $error("software trap number wrong");

  class_a_taken_c: cover property (taken && src_reg == SRC_A);
  fault_taken_c: cover property (taken && src_reg == SRC_B);
  node_taken_c: cover property (taken && src_reg == SRC_NODE);
  nested_c: cover property (svc_a_reg && svc_b_reg);

endmodule

// >>> tb/tb_trap_and_vector_unit.sv
module tb_trap_and_vector_unit
  import tvu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, irq, ovr, und, swt, wdg, srst, nmi_n, done, ack, bak;
  logic [4:0] flt;
  logic [2:0] nde;
  logic [6:0] swn;
  logic [1:0] svc;
  logic [3:0] dly;
  logic [7:0] taken_cnt, seen_cnt;
  logic [31:0] rdat, rd;
  tvu_wb_req_type wb_req;
  tvu_branch_type br, taken;
  int err_count, cmp_count, cyc;
  logic [7:0] amask [3] = '{8'h80, 8'h01, 8'h02};
  logic [6:0] atrap [3] = '{7'h02, 7'h04, 7'h06};
  logic [6:0] ntrap [3] = '{7'h20, 7'h2a, 7'h47};
  logic [23:0] nvec [3] = '{24'h000080, 24'h0000a8, 24'h00011c};
  logic [6:0] snum [4] = '{7'h00, 7'h01, 7'h47, 7'h7f};

  tvu_trap_unit dut (.clk_in(clk_in), .rst_in(rst_in), .wb_req_in(wb_req), .branch_out(br),
    .wb_ack_out(ack), .wb_dat_out(rdat), .irq_out(irq), .service_out(svc),
    .unmaskable_req_n_in(nmi_n), .stack_overrun_in(ovr), .stack_underrun_in(und),
    .fault_in(flt), .soft_reset_in(srst), .watchdog_overflow_in(wdg), .soft_trap_in(swt),
    .soft_trap_num_in(swn), .node_event_in(nde), .branch_ack_in(bak), .service_done_in(done));
  tvu_seq_model seq (.clk_in(clk_in), .rst_in(rst_in), .branch_in(br), .delay_in(dly),
    .ack_out(bak), .taken_out(taken), .taken_cnt_out(taken_cnt));

  // ***********************************************
  // helpers
  // ***********************************************
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    // no wait count assumed: a silent slave is caught by the cycle guard
    wb_req <= '{1'b1, 1'b1, we, 4'hf, adr, dat};
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    q = rdat;
    wb_req <= '0;
    @(posedge clk_in);
  endtask

  // pin held low a few edges so the synchroniser sees it
  task automatic kick(input logic [7:0] m, input logic [6:0] k);
    ovr <= m[0];
    und <= m[1];
    flt <= m[2] ? 5'h01 << k : 5'h00;
    nde <= m[3] ? 3'h1 << k : 3'h0;
    swt <= m[4];
    swn <= k;
    wdg <= m[5];
    srst <= m[6];
    nmi_n <= !m[7];
    @(posedge clk_in);
    {ovr, und, flt, nde, swt, wdg, srst} <= '0;
    repeat (3) @(posedge clk_in);
    nmi_n <= 1'b1;
  endtask

  task automatic take(input logic [6:0] t, input logic [23:0] v, input logic r);
    // a lost offer hangs here until the cycle guard ends the run
    while (taken_cnt === seen_cnt) begin
      @(posedge clk_in);
    end
    seen_cnt = taken_cnt;
    chk("branch", {r, t, v}, {taken.is_reset, taken.trap_num, taken.vector});
  endtask

  task automatic done_svc();
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic held(input int n);
    repeat (n) @(posedge clk_in);
    chk("no offer taken", {24'h0, seen_cnt}, {24'h0, taken_cnt});
  endtask

  // clock and hang guard; a run is under four hundred cycles
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_in);
      cyc++;
      if (cyc > 6000) begin
        err_count++;
        stop_test();
      end
    end
  end

  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    {ovr, und, flt, nde, swt, swn, wdg, srst, done, dly} = '0;
    nmi_n = 1'b1;
    wb_req = '0;
    rst_in = 1'b1;
    err_count = 0;
    cmp_count = 0;
    seen_cnt = 8'h00;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    take(7'h00, 24'h0, 1'b1);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk("flags after reset", 32'h0, rd);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    wb(1'b1, 8'h10, 32'h1, rd);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 8'h04, (i == 1) ? 32'h0 : 32'hff, rd);
      kick(amask[i], 7'h00);
      take(atrap[i], {15'h0, atrap[i], 2'b00}, 1'b0);
      chk("service", 32'h1, {30'h0, svc});
      wb(1'b0, 8'h00, 32'h0, rd);
      chk("flags", 32'h1 << i, rd);
      chk("irq", {31'h0, i != 1}, {31'h0, irq});
      done_svc();
      wb(1'b1, 8'h00, 32'h1 << i, rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      chk("flags cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    for (int k = 0; k < 5; k++) begin
      kick(8'h04, 7'(k));
      take(7'h0a, 24'h000028, 1'b0);
      chk("service", 32'h2, {30'h0, svc});
      wb(1'b0, 8'h00, 32'h0, rd);
      chk("fault flag", 32'h8 << k, rd);
      done_svc();
      wb(1'b1, 8'h00, 32'hff, rd);
    end
    dly <= 4'h3;
    foreach (snum[i]) begin
      kick(8'h10, snum[i]);
      take(snum[i], {15'h0, snum[i], 2'b00}, 1'b0);
      chk("service", 32'h0, {30'h0, svc});
    end
    wb(1'b1, 8'h0c, 32'h7, rd);
    for (int i = 0; i < 3; i++) begin
      dly <= 4'hf;
      kick(8'h08, 7'(i));
      wb(1'b0, 8'h08, 32'h0, rd);
      chk("node request", 32'h1 << i, rd);
      dly <= 4'h0;
      take(ntrap[i], nvec[i], 1'b0);
      wb(1'b0, 8'h08, 32'h0, rd);
      chk("node request", 32'h0, rd);
    end
    wb(1'b1, 8'h0c, 32'h6, rd);
    kick(8'h08, 7'h00);
    held(10);
    wb(1'b1, 8'h0c, 32'h7, rd);
    take(7'h20, 24'h000080, 1'b0);
    kick(8'h01, 7'h00);
    take(7'h04, 24'h000010, 1'b0);
    kick(8'h0c, 7'h00);
    held(12);
    kick(8'h10, 7'h7f);
    take(7'h7f, 24'h0001fc, 1'b0);
    done_svc();
    take(7'h0a, 24'h000028, 1'b0);
    chk("service", 32'h2, {30'h0, svc});
    done_svc();
    take(7'h20, 24'h000080, 1'b0);
    wb(1'b1, 8'h00, 32'hff, rd);
    dly <= 4'hf;
    kick(8'h07, 7'h01);
    dly <= 4'h0;
    take(7'h04, 24'h000010, 1'b0);
    done_svc();
    take(7'h06, 24'h000018, 1'b0);
    done_svc();
    take(7'h0a, 24'h000028, 1'b0);
    done_svc();
    dly <= 4'hf;
    kick(8'h21, 7'h00);
    dly <= 4'h0;
    take(7'h00, 24'h0, 1'b1);
    held(10);
    chk("service", 32'h0, {30'h0, svc});
    kick(8'h40, 7'h00);
    take(7'h00, 24'h0, 1'b1);
    stop_test();
  end
endmodule

// >>> tb/tvu_seq_model.sv
// ***********************************************
// sequencer model on the branch offer side
// ***********************************************
module tvu_seq_model
  import tvu_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tvu_branch_type branch_in,
  input wire logic [3:0] delay_in,
  output logic ack_out,
  output tvu_branch_type taken_out,
  output logic [7:0] taken_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;

  // take a live offer after delay_in cycles; 4'hf stalls so traps pile up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      taken_out <= '0;
      taken_cnt_out <= 8'h00;
      wait_reg <= 4'h0;
    end else if (ack_out && branch_in.valid) begin
      ack_out <= 1'b0;
      taken_out <= branch_in;
      taken_cnt_out <= taken_cnt_out + 8'h01;
      wait_reg <= 4'h0;
    end else if (!branch_in.valid) begin
      ack_out <= 1'b0;
      wait_reg <= 4'h0;
    end else if (delay_in != 4'hf) begin
      if (wait_reg >= delay_in) begin
        ack_out <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule
